// file: core/rco_pkg.sv
// package: constants and carrier types of the receive checksum offload block
package rco_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0]  OFF_CTRL       = 8'h00;
  localparam logic [7:0]  OFF_VLAN       = 8'h04;
  localparam logic [7:0]  OFF_STAT       = 8'h08;
  localparam logic [7:0]  OFF_FRAMES     = 8'h0C;
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_MODE_BIT  = 1;
  localparam logic [15:0] VLAN_RST       = 16'h8100;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic [1:0]  HRESP_OKAY     = 2'h0;

  // ---------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------
  localparam logic [15:0] HDR_BYTES      = 16'h000E;
  localparam logic [15:0] TYPE_POS       = 16'h000C;
  localparam logic [15:0] VLAN_TAG_BYTES = 16'h0004;
  localparam logic [15:0] TYPE_SKIP      = 16'h0001;
  localparam logic [15:0] SNAP_SKIP      = 16'h0009;
  localparam logic [15:0] LEN_LIMIT      = 16'h0600;
  localparam logic [15:0] NO_START       = 16'hFFFF;
  localparam logic [15:0] APPEND_BYTES   = 16'h0002;
  localparam logic [1:0]  MAX_VLAN       = 2'h2;
  localparam logic [7:0]  PAD_BYTE       = 8'h00;

  // ---------------------------------------------------------------
  // buffering
  // ---------------------------------------------------------------
  localparam int unsigned FIFO_DEPTH     = 8;
  localparam int unsigned FIFO_CW        = 4;
  localparam logic [3:0]  FREE_MARGIN    = 4'h3;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } rco_byte_t;

  typedef struct packed {
    logic [15:0] len;
    logic        appended;
  } rco_stat_t;

  typedef enum logic [1:0] {
    RCO_PASS,
    RCO_APP_LO,
    RCO_APP_HI
  } rco_phase_t;

endpackage

// file: core/rco_top.sv
// receive checksum offload engine with its output fifo and ahb-lite slave
//
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------
// byte fifo
// -----------------------------------------------------------------
module rco_fifo #(
  parameter int unsigned W     = 9,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         ce,
  input  wire logic                         s_valid,
  input  wire logic [W-1:0]                 s_data,
  output logic                              s_ready,
  output logic                              m_valid,
  output logic [W-1:0]                      m_data,
  input  wire logic                         m_ready,
  output logic [$clog2(DEPTH+1)-1:0]        free
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [CW-1:0]           cnt;
    logic                    nempty;
    logic                    full;
  } rco_fifo_st_t;

  rco_fifo_st_t st;
  rco_fifo_st_t next_st;
  logic         push;
  logic         pop;

  assign push    = s_valid && !st.full;
  assign pop     = st.nempty && m_ready;
  assign s_ready = !st.full;
  assign m_valid = st.nempty;
  assign m_data  = st.mem[st.rp];
  assign free    = CW'(DEPTH) - st.cnt;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = s_data;
      next_st.wp         = st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = st.rp + 1'b1;
    end
    if (push && !pop) begin
      next_st.cnt = st.cnt + 1'b1;
    end else if (pop && !push) begin
      next_st.cnt = st.cnt - 1'b1;
    end
    next_st.nempty = (next_st.cnt != '0);
    next_st.full   = (next_st.cnt == CW'(DEPTH));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end
endmodule

// -----------------------------------------------------------------
// checksum engine top
// -----------------------------------------------------------------
module rco_top (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic [1:0]              hresp,
  output logic [31:0]             hrdata,
  input  wire logic               in_valid,
  input  wire rco_pkg::rco_byte_t in_byte,
  output logic                    in_ready,
  output logic                    out_valid,
  output rco_pkg::rco_byte_t      out_byte,
  input  wire logic               out_ready,
  output logic                    stat_valid,
  output rco_pkg::rco_stat_t      stat_info
);
  typedef struct packed {
    rco_pkg::rco_phase_t phase;
    logic [15:0]         cnt;
    logic [15:0]         flen;
    logic [15:0]         acc;
    logic [15:0]         chk;
    logic [7:0]          lo;
    logic                have_lo;
    logic [15:0]         tpos;
    logic [15:0]         start;
    logic [7:0]          thi;
    logic [1:0]          vlan_n;
    logic                en_f;
    logic                mode_f;
    logic                s_valid;
    rco_pkg::rco_byte_t  s_data;
    logic                in_rdy;
    logic                stv;
    rco_pkg::rco_stat_t  sti;
    logic                ctl_en;
    logic                ctl_mode;
    logic [15:0]         vlan;
    logic [15:0]         last_sum;
    logic [31:0]         frames;
    logic                dp_act;
    logic                dp_wr;
    logic [7:0]          dp_addr;
    logic                hro;
    logic [31:0]         hrd;
  } rco_st_t;

  rco_st_t                         st;
  rco_st_t                         next_st;
  logic                            f_ready;
  logic [rco_pkg::FIFO_CW-1:0]     f_free;
  logic                            acc_in;
  logic                            en_now;
  logic                            mode_now;

  assign acc_in   = in_valid && st.in_rdy;
  assign en_now   = (st.cnt == '0) ? st.ctl_en : st.en_f;
  assign mode_now = (st.cnt == '0) ? st.ctl_mode : st.mode_f;

  rco_fifo #(
    .W     ($bits(rco_pkg::rco_byte_t)),
    .DEPTH (rco_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .s_valid (st.s_valid),
    .s_data  (st.s_data),
    .s_ready (f_ready),
    .m_valid (out_valid),
    .m_data  (out_byte),
    .m_ready (out_ready),
    .free    (f_free)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic        first;
    logic [15:0] acc;
    logic [7:0]  lo;
    logic        have;
    logic [15:0] tpos;
    logic [15:0] start;
    logic [1:0]  vn;
    logic [15:0] tword;
    logic [16:0] sum17;
    logic [31:0] rd;
    first   = (st.cnt == '0);
    acc     = first ? '0 : st.acc;
    lo      = st.lo;
    have    = first ? 1'b0 : st.have_lo;
    tpos    = first ? rco_pkg::TYPE_POS : st.tpos;
    start   = st.start;
    vn      = first ? '0 : st.vlan_n;
    tword   = {st.thi, in_byte.data};
    sum17   = '0;
    rd      = '0;
    next_st = st;
    next_st.stv = 1'b0;
    if (st.s_valid && f_ready) begin
      next_st.s_valid = 1'b0;
    end
    unique case (st.phase)
      rco_pkg::RCO_PASS: begin
        if (acc_in) begin
          if (first) begin
            start = mode_now ? rco_pkg::NO_START : rco_pkg::HDR_BYTES;
          end
          if (mode_now && start == rco_pkg::NO_START) begin
            if (st.cnt == tpos) begin
              next_st.thi = in_byte.data;
            end else if (st.cnt == tpos + rco_pkg::TYPE_SKIP) begin
              if (tword == st.vlan && vn < rco_pkg::MAX_VLAN) begin
                tpos = tpos + rco_pkg::VLAN_TAG_BYTES;
                vn   = vn + 2'h1;
              end else if (tword < rco_pkg::LEN_LIMIT) begin
                start = st.cnt + rco_pkg::SNAP_SKIP;
              end else begin
                start = st.cnt + rco_pkg::TYPE_SKIP;
              end
            end
          end
          if (en_now && st.cnt >= start) begin
            if (have) begin
              sum17 = {1'b0, acc} + {1'b0, in_byte.data, lo};
              acc   = sum17[15:0] + {15'h0000, sum17[16]};
              have  = 1'b0;
            end else begin
              lo   = in_byte.data;
              have = 1'b1;
            end
          end
          if (in_byte.last && en_now && have) begin
            sum17 = {1'b0, acc} + {1'b0, rco_pkg::PAD_BYTE, lo};
            acc   = sum17[15:0] + {15'h0000, sum17[16]};
            have  = 1'b0;
          end
          next_st.en_f        = en_now;
          next_st.mode_f      = mode_now;
          next_st.acc         = acc;
          next_st.lo          = lo;
          next_st.have_lo     = have;
          next_st.tpos        = tpos;
          next_st.start       = start;
          next_st.vlan_n      = vn;
          next_st.s_valid     = 1'b1;
          next_st.s_data.data = in_byte.data;
          next_st.s_data.last = in_byte.last && !en_now;
          next_st.flen        = st.cnt + 16'h0001;
          next_st.cnt         = in_byte.last ? '0 : st.cnt + 16'h0001;
          if (in_byte.last) begin
            next_st.frames = st.frames + 32'h0000_0001;
            if (en_now) begin
              next_st.phase = rco_pkg::RCO_APP_LO;
              next_st.chk   = acc;
            end else begin
              next_st.stv          = 1'b1;
              next_st.sti.len      = st.cnt + 16'h0001;
              next_st.sti.appended = 1'b0;
            end
          end
        end
      end
      // append low byte then high byte
      rco_pkg::RCO_APP_LO: begin
        if (!next_st.s_valid) begin
          next_st.s_valid     = 1'b1;
          next_st.s_data.data = st.chk[7:0];
          next_st.s_data.last = 1'b0;
          next_st.phase       = rco_pkg::RCO_APP_HI;
        end
      end
      rco_pkg::RCO_APP_HI: begin
        if (!next_st.s_valid) begin
          next_st.s_valid      = 1'b1;
          next_st.s_data.data  = st.chk[15:8];
          next_st.s_data.last  = 1'b1;
          next_st.phase        = rco_pkg::RCO_PASS;
          next_st.last_sum     = st.chk;
          next_st.stv          = 1'b1;
          next_st.sti.len      = st.flen + rco_pkg::APPEND_BYTES;
          next_st.sti.appended = 1'b1;
        end
      end
    endcase
    // margin covers bytes already in flight to the fifo
    next_st.in_rdy = (next_st.phase == rco_pkg::RCO_PASS) &&
                     (f_free >= rco_pkg::FREE_MARGIN);

    // -------------------------------------------------------------
    // ahb-lite slave, zero wait states
    // -------------------------------------------------------------
    if (st.dp_act && st.dp_wr) begin
      unique case (st.dp_addr)
        rco_pkg::OFF_CTRL: begin
          next_st.ctl_en   = hwdata[rco_pkg::CTRL_EN_BIT];
          next_st.ctl_mode = hwdata[rco_pkg::CTRL_MODE_BIT];
        end
        rco_pkg::OFF_VLAN: begin
          next_st.vlan = hwdata[15:0];
        end
        default: begin
        end
      endcase
    end
    unique case (haddr[7:0])
      rco_pkg::OFF_CTRL: begin
        rd[rco_pkg::CTRL_EN_BIT]   = st.ctl_en;
        rd[rco_pkg::CTRL_MODE_BIT] = st.ctl_mode;
      end
      rco_pkg::OFF_VLAN:   rd = {16'h0000, st.vlan};
      rco_pkg::OFF_STAT:   rd = {st.sti.len, st.last_sum};
      rco_pkg::OFF_FRAMES: rd = st.frames;
      default:             rd = '0;
    endcase
    if (haddr[31:8] != '0) begin
      rd = '0;
    end
    next_st.dp_act  = hsel && hready && (htrans == rco_pkg::HTRANS_NONSEQ);
    next_st.dp_wr   = hwrite;
    next_st.dp_addr = (haddr[31:8] == '0) ? haddr[7:0] : 8'hFF;
    next_st.hrd     = (next_st.dp_act && !hwrite) ? rd : st.hrd;
    next_st.hro     = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st      <= '0;
      st.vlan <= rco_pkg::VLAN_RST;
      st.hro  <= 1'b1;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign hreadyout  = st.hro;
  assign hresp      = rco_pkg::HRESP_OKAY;
  assign hrdata     = st.hrd;
  assign in_ready   = st.in_rdy;
  assign stat_valid = st.stv;
  assign stat_info  = st.sti;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic        go;
  logic [15:0] tw;
  logic [16:0] ref_pair;
  logic [16:0] ref_odd;
  assign go       = acc_in && ce;
  assign tw       = {st.thi, in_byte.data};
  assign ref_pair = {1'b0, st.acc} + {1'b0, in_byte.data, st.lo};
  assign ref_odd  = {1'b0, st.acc} + {1'b0, rco_pkg::PAD_BYTE, in_byte.data};

  sequence seq_lo_out;
    st.phase == rco_pkg::RCO_APP_HI && st.s_valid &&
      st.s_data.data == st.chk[7:0] && !st.s_data.last;
  endsequence
  sequence seq_hi_out;
    st.phase == rco_pkg::RCO_PASS && st.s_valid && st.s_data.last &&
      st.stv && st.sti.appended;
  endsequence

  AST_FRAME_CLEAR: assert property (
    go && st.cnt == '0 |=> st.acc == '0 && !st.have_lo)
    else $error("accumulator not cleared at frame start");
  AST_MODE_LATCH: assert property (
    go && st.cnt == '0 |=> st.mode_f == $past(st.ctl_mode) &&
      st.en_f == $past(st.ctl_en))
    else $error("enable or mode not taken at frame start");
  AST_HDR_SKIP: assert property (
    go && st.cnt != '0 && !st.mode_f && st.cnt < rco_pkg::HDR_BYTES
      |=> st.acc == $past(st.acc) && !st.have_lo)
    else $error("header byte entered the sum");
  AST_VLAN_SKIP: assert property (
    go && mode_now && st.cnt != '0 && st.start == rco_pkg::NO_START &&
      st.cnt == st.tpos + rco_pkg::TYPE_SKIP && tw == st.vlan &&
      st.vlan_n < rco_pkg::MAX_VLAN
      |=> st.tpos == $past(st.tpos) + rco_pkg::VLAN_TAG_BYTES &&
        st.start == rco_pkg::NO_START)
    else $error("vlan tag not skipped");
  AST_THIRD_TAG: assert property (
    go && mode_now && st.cnt != '0 && st.start == rco_pkg::NO_START &&
      st.cnt == st.tpos + rco_pkg::TYPE_SKIP && st.vlan_n == rco_pkg::MAX_VLAN
      && tw >= rco_pkg::LEN_LIMIT
      |=> st.start == $past(st.cnt) + rco_pkg::TYPE_SKIP)
    else $error("third tag not taken as type");
  AST_SNAP_SKIP: assert property (
    go && mode_now && st.cnt != '0 && st.start == rco_pkg::NO_START &&
      st.cnt == st.tpos + rco_pkg::TYPE_SKIP && tw != st.vlan &&
      tw < rco_pkg::LEN_LIMIT
      |=> st.start == $past(st.cnt) + rco_pkg::SNAP_SKIP)
    else $error("snap header not skipped");
  AST_WORD_SUM: assert property (
    go && st.cnt != '0 && st.en_f && st.cnt >= st.start && st.have_lo &&
      !in_byte.last
      |=> st.acc == $past(ref_pair[15:0] + {15'h0000, ref_pair[16]}))
    else $error("word sum or end-around carry wrong");
  AST_ODD_PAD: assert property (
    go && st.cnt != '0 && st.en_f && st.cnt >= st.start && !st.have_lo &&
      in_byte.last
      |=> st.chk == $past(ref_odd[15:0] + {15'h0000, ref_odd[16]}))
    else $error("odd byte not padded with zero high");
  AST_APPEND: assert property (
    go && in_byte.last && en_now
      |=> st.phase == rco_pkg::RCO_APP_LO ##[1:8] seq_lo_out
        ##[1:8] seq_hi_out)
    else $error("checksum not appended after last byte");
  AST_LEN_PLUS2: assert property (
    st.stv && st.sti.appended |-> st.sti.len == st.flen + 16'h0002)
    else $error("reported length not two larger");
  AST_BYPASS: assert property (
    go && !en_now |=> st.s_valid && st.s_data == $past(in_byte) &&
      st.phase == rco_pkg::RCO_PASS)
    else $error("bypass frame altered");
  AST_NO_SUM_OFF: assert property (
    go && st.cnt != '0 && !st.en_f |=> st.acc == $past(st.acc))
    else $error("sum moved while engine off");

endmodule
`default_nettype wire

// file: dv/rco_sink.sv
// receive fifo side model: stalls at random and collects every byte taken
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// sink
// ---------------------------------------------------------------
module rco_sink (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               out_valid,
  input  wire rco_pkg::rco_byte_t out_byte,
  output logic                    out_ready
);
  rco_pkg::rco_byte_t got[$];

  initial out_ready = 1'b0;

  // stalls about one cycle in four so the fifo backs up
  always @(posedge clk) begin
    if (rst_n && out_valid === 1'b1 && out_ready) begin
      got.push_back(out_byte);
    end
    out_ready <= rst_n && ($urandom % 4 != 0);
  end
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench of the receive checksum offload block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               ce = 1'b1;
  logic               hsel = 1'b0;
  logic [31:0]        haddr = 32'h0;
  logic [1:0]         htrans = 2'h0;
  logic [2:0]         hsize = 3'h0;
  logic               hwrite = 1'b0;
  logic [31:0]        hwdata = 32'h0;
  logic               in_valid = 1'b0;
  rco_pkg::rco_byte_t in_byte = '0;
  wire logic          hready;
  logic               hreadyout;
  logic [1:0]         hresp;
  logic [31:0]        hrdata;
  logic               in_ready;
  logic               out_valid;
  rco_pkg::rco_byte_t out_byte;
  logic               out_ready;
  logic               stat_valid;
  rco_pkg::rco_stat_t stat_info;
  rco_pkg::rco_stat_t stq[$];
  logic [7:0]         frm[$];
  logic [15:0]        tv;
  logic               mode;
  logic [31:0]        rd;
  int                 fail_count = 0;
  int                 checked = 0;
  int                 cyc = 0;

  assign hready = hreadyout;

  rco_top DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .in_valid(in_valid), .in_byte(in_byte), .in_ready(in_ready),
    .out_valid(out_valid), .out_byte(out_byte), .out_ready(out_ready),
    .stat_valid(stat_valid), .stat_info(stat_info));

  rco_sink sink (.clk(clk), .rst_n(rst_n), .out_valid(out_valid),
    .out_byte(out_byte), .out_ready(out_ready));

  always #2 clk = ~clk;

  always @(posedge clk) begin
    if (stat_valid === 1'b1) begin
      stq.push_back(stat_info);
    end
    cyc++;
    if (cyc == 80000) begin
      fail_count++;
      conclude();
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic conclude();
    if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rdv);
    hsel   <= 1'b1;
    htrans <= rco_pkg::HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= 3'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rdv = hrdata;
  endtask

  // ce low: a byte on offer must not be taken, nothing moves
  task automatic freeze(input int n);
    sink.got = {};
    stq = {};
    ce       <= 1'b0;
    in_valid <= 1'b1;
    in_byte  <= '{8'($urandom), 1'b1};
    repeat (n) @(posedge clk);
    ce       <= 1'b1;
    in_valid <= 1'b0;
    repeat (6) @(posedge clk);
    chk(sink.got.size() + stq.size(), 0);
  endtask

  // start point follows tags and snap header in protocol mode
  function automatic logic [15:0] exp_sum();
    int          p;
    int          t;
    int          st;
    logic [15:0] ty;
    logic [15:0] w;
    logic [16:0] a;
    p = 12;
    t = 0;
    st = 14;
    if (mode) begin
      ty = {frm[p], frm[p+1]};
      while (ty == tv && t < 2) begin
        p += 4;
        t++;
        ty = {frm[p], frm[p+1]};
      end
      st = (ty < rco_pkg::LEN_LIMIT) ? p + 10 : p + 2;
    end
    a = 17'h0;
    for (int i = st; i < frm.size(); i += 2) begin
      w = {(i + 1 < frm.size()) ? frm[i+1] : 8'h00, frm[i]};
      a = {1'b0, a[15:0]} + {1'b0, w};
      a = {1'b0, a[15:0]} + {16'h0, a[16]};
    end
    return a[15:0];
  endfunction

  task automatic mk(input int kind, input int len);
    int ntag[6] = '{0, 1, 2, 3, 0, 1};
    frm = {};
    repeat (12) frm.push_back(8'($urandom));
    repeat (ntag[kind]) begin
      frm.push_back(tv[15:8]);
      frm.push_back(tv[7:0]);
      frm.push_back(8'($urandom));
      frm.push_back(8'($urandom));
    end
    if (kind >= 4) begin
      frm.push_back(8'h00);
      frm.push_back(8'h40);
      frm.push_back(8'hAA);
      frm.push_back(8'hAA);
      frm.push_back(8'h03);
      repeat (5) frm.push_back(8'($urandom));
    end else begin
      frm.push_back(8'h08);
      frm.push_back(8'h00);
    end
    while (frm.size() < len) frm.push_back(8'($urandom));
  endtask

  task automatic run(input logic en);
    rco_pkg::rco_byte_t e[$];
    logic [15:0]        s;
    int                 n;
    n = frm.size();
    s = exp_sum();
    foreach (frm[i]) e.push_back('{frm[i], !en && i == n - 1});
    if (en) begin
      e.push_back('{s[7:0], 1'b0});
      e.push_back('{s[15:8], 1'b1});
    end
    sink.got = {};
    stq = {};
    for (int i = 0; i < n; i++) begin
      in_valid <= 1'b1;
      in_byte  <= '{frm[i], i == n - 1};
      @(posedge clk);
      while (in_ready !== 1'b1) @(posedge clk);
      if ($urandom % 5 == 0) begin
        in_valid <= 1'b0;
        @(posedge clk);
      end
    end
    in_valid <= 1'b0;
    while (sink.got.size() < e.size() || stq.size() == 0) @(posedge clk);
    repeat (4) @(posedge clk);
    chk(sink.got.size(), e.size());
    foreach (e[i]) chk({23'h0, sink.got[i]}, {23'h0, e[i]});
    chk({15'h0, stq[0]}, {15'h0, 16'(n + (en ? 2 : 0)), en});
    if (en) begin
      ahb(1'b0, {24'h0, rco_pkg::OFF_STAT}, 32'h0, rd);
      chk(rd, {16'(n + 2), s});
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h9C3BBE67));
    tv = rco_pkg::VLAN_RST;
    mode = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    ahb(1'b0, {24'h0, rco_pkg::OFF_CTRL}, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'b0, {24'h0, rco_pkg::OFF_VLAN}, 32'h0, rd);
    chk(rd, {16'h0, rco_pkg::VLAN_RST});
    ahb(1'b1, 32'h0000_0010, 32'hFFFF_FFFF, rd);
    ahb(1'b0, 32'h0000_0010, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'b0, 32'h0000_0100, 32'h0, rd);
    chk(rd, 32'h0);
    freeze(2 + int'($urandom % 6));
    for (int k = 0; k < 4; k++) begin
      mk(k, 30 + k);
      run(1'b0);
    end
    for (int m = 0; m < 2; m++) begin
      mode = m[0];
      ahb(1'b1, {24'h0, rco_pkg::OFF_CTRL}, {30'h0, mode, 1'b1}, rd);
      ahb(1'b0, {24'h0, rco_pkg::OFF_CTRL}, 32'h0, rd);
      chk(rd, {30'h0, mode, 1'b1});
      freeze(2 + int'($urandom % 6));
      for (int k = 0; k < 12; k++) begin
        mk(k % 6, 40 + k + int'($urandom % 20));
        run(1'b1);
      end
    end
    tv = 16'h9100;
    ahb(1'b1, {24'h0, rco_pkg::OFF_VLAN}, {16'h0, tv}, rd);
    for (int k = 1; k < 6; k++) begin
      mk(k, 41 + k);
      run(1'b1);
    end
    conclude();
  end
endmodule
`default_nettype wire
